// ==== verilog/uart_core_pkg.sv ====
package uart_core_pkg;

  // ----------------------------------------------------------------
  // Clock rates
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned INT_BAUD_HZ  = 1_843_200;
  localparam logic [25:0] PHASE_INC    = 26'(INT_BAUD_HZ);
  localparam logic [25:0] PHASE_WRAP   = 26'(CLK_HZ);

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IER  = 3'h1;
  localparam logic [2:0] OFS_IIR  = 3'h2;
  localparam logic [2:0] OFS_LCR  = 3'h3;
  localparam logic [2:0] OFS_MCR  = 3'h4;
  localparam logic [2:0] OFS_LSR  = 3'h5;
  localparam logic [2:0] OFS_MSR  = 3'h6;
  localparam logic [2:0] OFS_SCR  = 3'h7;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int LCR_ACCESS = 7;
  localparam int LCR_BREAK  = 6;
  localparam int LCR_STICK  = 5;
  localparam int LCR_EVEN   = 4;
  localparam int LCR_PAR_EN = 3;
  localparam int LCR_STOP   = 2;
  localparam int MCR_DTR    = 0;
  localparam int MCR_RTS    = 1;
  localparam int MCR_GATE   = 3;
  localparam int DHL_FAST   = 7;
  localparam int IER_RDA    = 0;
  localparam int IER_THRE   = 1;
  localparam int IER_RLS    = 2;
  localparam int IER_MS     = 3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] IID_NONE = 4'h1;
  localparam logic [3:0] IID_RLS  = 4'h6;
  localparam logic [3:0] IID_RDA  = 4'h4;
  localparam logic [3:0] IID_THRE = 4'h2;
  localparam logic [3:0] IID_MS   = 4'h0;

  // ----------------------------------------------------------------
  // Serial timing in 16x ticks
  // ----------------------------------------------------------------
  localparam logic [5:0] TICK_BIT_END  = 6'h0F;
  localparam logic [5:0] TICK_MID      = 6'h07;
  localparam logic [5:0] TICK_STOP1    = 6'h0F;
  localparam logic [5:0] TICK_STOP15   = 6'h17;
  localparam logic [5:0] TICK_STOP2    = 6'h1F;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum {SER_IDLE, SER_START, SER_DATA, SER_PARITY, SER_STOP} ser_state_t;

endpackage

// ==== verilog/uart_baud_and_buffer_core.sv ====
`timescale 1ns/1ps
module sync3 #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clock_in,
  input  wire logic         arst_n_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // Level moves only where the last two stages agree
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_r      <= INIT;
      s2_r      <= INIT;
      s3_r      <= INIT;
      level_out <= INIT;
    end else begin
      s1_r      <= async_in;
      s2_r      <= s1_r;
      s3_r      <= s2_r;
      level_out <= (s2_r & ~(s2_r ^ s3_r)) | (level_out & (s2_r ^ s3_r));
    end
  end
endmodule

module uart_baud_and_buffer_core
  import uart_core_pkg::*;
(
  input  wire logic     clock_in,
  input  wire logic     arst_n_in,
  input  wire logic     power_select_in,
  input  wire logic     main_rail_reset_n_in,
  input  wire logic     low_power_req_in,
  input  wire logic     external_clock_select_in,
  input  wire logic     ext_baud_clk_in,
  input  wire reg_req_t reg_req_in,
  input  wire logic     rxd_in,
  input  wire logic     cts_n_in,
  input  wire logic     dsr_n_in,
  input  wire logic     ri_n_in,
  input  wire logic     dcd_n_in,
  output logic [7:0]    reg_rdata_out,
  output logic          txd_out,
  output logic          dtr_n_out,
  output logic          rts_n_out,
  output logic          irq_out,
  output logic          baud16_out,
  output logic          low_power_ack_out
);
  logic [7:0]  dll_r, dhl_r, lcr_r, mcr_r, scr_r, rbr_r, thr_r;
  logic [3:0]  ier_r, delta_r, ms_lvl, ms_prev_r, iir_id;
  logic        fifo_en_r, main_rst_lvl, blk_clr, ext_lvl, ext_prev_r, rx_lvl;
  logic [25:0] phase_r;
  logic        int_tick_r, src_tick, baud_tick_r;
  logic [14:0] divisor, count_r, period, div_wr_val, cnt_next;
  logic        div_wr;
  logic        thr_full_r, thre_int_r, tx_load, tx_par_r;
  logic [7:0]  tx_shift_r, rx_shift_r;
  logic [5:0]  tx_sub_r, rx_sub_r, stop_end;
  logic [2:0]  tx_bit_r, rx_bit_r;
  ser_state_t  tx_state_r, rx_state_r;
  logic        tx_line, dr_r, oe_r, pe_r, fe_r, bi_r, rx_pe_r, int_pend;
  logic        wr, rd, access;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in || blk_clr);

  function automatic logic [14:0] period_of(input logic [14:0] d);
    period_of = (d == 15'h0000) ? 15'h0003 : d;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and block reset
  // ----------------------------------------------------------------
  sync3 #(.W(1), .INIT(1'b1)) u_main_rst (
    .clock_in  (clock_in),
    .arst_n_in (arst_n_in),
    .async_in  (main_rail_reset_n_in),
    .level_out (main_rst_lvl)
  );
  sync3 #(.W(1), .INIT(1'b0)) u_ext_clk (
    .clock_in  (clock_in),
    .arst_n_in (arst_n_in),
    .async_in  (ext_baud_clk_in),
    .level_out (ext_lvl)
  );
  sync3 #(.W(1), .INIT(1'b1)) u_rxd (
    .clock_in  (clock_in),
    .arst_n_in (arst_n_in),
    .async_in  (rxd_in),
    .level_out (rx_lvl)
  );
  sync3 #(.W(4), .INIT(4'hF)) u_modem (
    .clock_in  (clock_in),
    .arst_n_in (arst_n_in),
    .async_in  ({dcd_n_in, ri_n_in, dsr_n_in, cts_n_in}),
    .level_out (ms_lvl)
  );

  // Core reset is the asynchronous one; main rail adds a synchronous clear while power select is high
  assign blk_clr = power_select_in & ~main_rst_lvl;
  assign wr      = reg_req_in.wr;
  assign rd      = reg_req_in.rd;
  assign access  = lcr_r[LCR_ACCESS];

  // ----------------------------------------------------------------
  // Host registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in || blk_clr) begin
      dll_r     <= RST_BYTE;
      dhl_r     <= RST_BYTE;
      ier_r     <= 4'h0;
      lcr_r     <= RST_BYTE;
      mcr_r     <= RST_BYTE;
      scr_r     <= RST_BYTE;
      fifo_en_r <= 1'b0;
    end else if (wr) begin
      case (reg_req_in.addr)
        OFS_DATA: if (access) dll_r <= reg_req_in.wdata;
        OFS_IER: begin
          if (access) dhl_r <= reg_req_in.wdata;
          else ier_r <= reg_req_in.wdata[3:0];
        end
        OFS_IIR: fifo_en_r <= reg_req_in.wdata[0];
        OFS_LCR: lcr_r <= reg_req_in.wdata;
        OFS_MCR: mcr_r <= reg_req_in.wdata;
        OFS_SCR: scr_r <= reg_req_in.wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Baud source and rate divider
  // ----------------------------------------------------------------
  assign divisor = {dhl_r[6:0], dll_r};
  assign period  = period_of(divisor);
  assign div_wr  = wr && access && (reg_req_in.addr == OFS_DATA || reg_req_in.addr == OFS_IER);
  assign div_wr_val = (reg_req_in.addr == OFS_DATA) ? {dhl_r[6:0], reg_req_in.wdata}
                                                    : {reg_req_in.wdata[6:0], dll_r};
  assign cnt_next = (count_r <= 15'h0001) ? period : count_r - 15'h0001;

  // Fractional accumulator: 1.8432MHz enable from the 50MHz clock, jitter one cycle
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in || blk_clr) begin
      phase_r    <= 26'h0000000;
      int_tick_r <= 1'b0;
    end else if (phase_r + PHASE_INC >= PHASE_WRAP) begin
      phase_r    <= phase_r + PHASE_INC - PHASE_WRAP;
      int_tick_r <= 1'b1;
    end else begin
      phase_r    <= phase_r + PHASE_INC;
      int_tick_r <= 1'b0;
    end
  end

  // Fast source is the main clock itself; low power stops every source
  always_comb begin
    if (low_power_req_in) src_tick = 1'b0;
    else if (external_clock_select_in) src_tick = ext_lvl & ~ext_prev_r;
    else if (dhl_r[DHL_FAST]) src_tick = 1'b1;
    else src_tick = int_tick_r;
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in || blk_clr) begin
      ext_prev_r  <= 1'b0;
      count_r     <= 15'h0003;
      baud16_out  <= 1'b1;
      baud_tick_r <= 1'b0;
    end else begin
      ext_prev_r  <= ext_lvl;
      baud_tick_r <= 1'b0;
      if (div_wr) begin
        count_r <= period_of(div_wr_val);
      end else if (src_tick) begin
        count_r     <= cnt_next;
        baud_tick_r <= (count_r <= 15'h0001);
        if (period == 15'h0001) baud16_out <= ~baud16_out;
        else baud16_out <= !(cnt_next == period ||
                             (period >= 15'h0003 && cnt_next == period - 15'h0001));
      end
    end
  end

  property p_div_reload;
    div_wr |=> count_r == period_of($past(div_wr_val));
  endproperty
  a_div_reload: assert property (p_div_reload) else $error("divisor write did not reload");

  property p_div_one;
    src_tick && !div_wr && period == 15'h0001 |=> baud16_out != $past(baud16_out);
  endproperty
  a_div_one: assert property (p_div_one) else $error("divisor one not inverting");

  sequence s_wrap3;
    src_tick && !div_wr && count_r == 15'h0001 && period >= 15'h0003;
  endsequence
  property p_low_two;
    s_wrap3 |=> !baud16_out;
  endproperty
  a_low_two: assert property (p_low_two) else $error("divider output not low at wrap");

  property p_lp_quiet;
    low_power_req_in |=> !baud_tick_r;
  endproperty
  a_lp_quiet: assert property (p_lp_quiet) else $error("baud tick during low power");

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  assign stop_end = !lcr_r[LCR_STOP] ? TICK_STOP1 :
                    (lcr_r[1:0] == 2'b00) ? TICK_STOP15 : TICK_STOP2;
  assign tx_load  = baud_tick_r && tx_state_r == SER_IDLE && thr_full_r;

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in || blk_clr) begin
      tx_state_r <= SER_IDLE;
      tx_shift_r <= RST_BYTE;
      tx_sub_r   <= 6'h00;
      tx_bit_r   <= 3'h0;
      tx_par_r   <= 1'b0;
    end else if (baud_tick_r) begin
      tx_sub_r <= tx_sub_r + 6'h01;
      case (tx_state_r)
        SER_IDLE: begin
          tx_sub_r <= 6'h00;
          if (thr_full_r) begin
            tx_shift_r <= thr_r;
            tx_bit_r   <= 3'h0;
            tx_par_r   <= lcr_r[LCR_STICK] ? ~lcr_r[LCR_EVEN] :
                          (lcr_r[LCR_EVEN] ? ^thr_r : ~^thr_r);
            tx_state_r <= SER_START;
          end
        end
        SER_START: if (tx_sub_r == TICK_BIT_END) begin
          tx_sub_r   <= 6'h00;
          tx_state_r <= SER_DATA;
        end
        SER_DATA: if (tx_sub_r == TICK_BIT_END) begin
          tx_sub_r   <= 6'h00;
          tx_shift_r <= {1'b0, tx_shift_r[7:1]};
          tx_bit_r   <= tx_bit_r + 3'h1;
          if (tx_bit_r == 3'h7) tx_state_r <= lcr_r[LCR_PAR_EN] ? SER_PARITY : SER_STOP;
        end
        SER_PARITY: if (tx_sub_r == TICK_BIT_END) begin
          tx_sub_r   <= 6'h00;
          tx_state_r <= SER_STOP;
        end
        SER_STOP: if (tx_sub_r == stop_end) tx_state_r <= SER_IDLE;
        default: tx_state_r <= SER_IDLE;
      endcase
    end
  end

  // Holding byte: a host write wins over the load that empties it
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in || blk_clr) begin
      thr_r      <= RST_BYTE;
      thr_full_r <= 1'b0;
      thre_int_r <= 1'b0;
    end else begin
      if (tx_load) begin
        thr_full_r <= 1'b0;
        thre_int_r <= 1'b1;
      end else if (rd && reg_req_in.addr == OFS_IIR && iir_id == IID_THRE) begin
        thre_int_r <= 1'b0;
      end
      if (wr && !access && reg_req_in.addr == OFS_DATA) begin
        thr_r      <= reg_req_in.wdata;
        thr_full_r <= 1'b1;
        thre_int_r <= 1'b0;
      end
    end
  end

  always_comb begin
    case (tx_state_r)
      SER_START:  tx_line = 1'b0;
      SER_DATA:   tx_line = tx_shift_r[0];
      SER_PARITY: tx_line = tx_par_r;
      default:    tx_line = 1'b1;
    endcase
  end

  property p_hold_full;
    thr_full_r && !tx_load |=> thr_full_r;
  endproperty
  a_hold_full: assert property (p_hold_full) else $error("holding byte lost before load");

  sequence s_tx_load;
    tx_load && !lcr_r[LCR_BREAK];
  endsequence
  property p_tx_start;
    s_tx_load ##1 !lcr_r[LCR_BREAK] |=> !txd_out;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("start bit missing after load");

  // ----------------------------------------------------------------
  // Receiver and line status
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in || blk_clr) begin
      rx_state_r <= SER_IDLE;
      rx_shift_r <= RST_BYTE;
      rx_sub_r   <= 6'h00;
      rx_bit_r   <= 3'h0;
      rx_pe_r    <= 1'b0;
      rbr_r      <= RST_BYTE;
      dr_r       <= 1'b0;
      oe_r       <= 1'b0;
      pe_r       <= 1'b0;
      fe_r       <= 1'b0;
      bi_r       <= 1'b0;
    end else begin
      if (rd && !access && reg_req_in.addr == OFS_DATA) dr_r <= 1'b0;
      if (rd && reg_req_in.addr == OFS_LSR) begin
        oe_r <= 1'b0;
        pe_r <= 1'b0;
        fe_r <= 1'b0;
        bi_r <= 1'b0;
      end
      if (baud_tick_r) begin
        rx_sub_r <= rx_sub_r + 6'h01;
        case (rx_state_r)
          SER_IDLE: begin
            rx_sub_r <= 6'h00;
            if (!rx_lvl) rx_state_r <= SER_START;
          end
          SER_START: if (rx_sub_r == TICK_MID) begin
            rx_sub_r   <= 6'h00;
            rx_bit_r   <= 3'h0;
            rx_state_r <= rx_lvl ? SER_IDLE : SER_DATA;
          end
          SER_DATA: if (rx_sub_r == TICK_BIT_END) begin
            rx_sub_r   <= 6'h00;
            rx_shift_r <= {rx_lvl, rx_shift_r[7:1]};
            rx_bit_r   <= rx_bit_r + 3'h1;
            rx_pe_r    <= 1'b0;
            if (rx_bit_r == 3'h7) rx_state_r <= lcr_r[LCR_PAR_EN] ? SER_PARITY : SER_STOP;
          end
          SER_PARITY: if (rx_sub_r == TICK_BIT_END) begin
            rx_sub_r   <= 6'h00;
            rx_pe_r    <= rx_lvl != (lcr_r[LCR_STICK] ? ~lcr_r[LCR_EVEN] :
                          (lcr_r[LCR_EVEN] ? ^rx_shift_r : ~^rx_shift_r));
            rx_state_r <= SER_STOP;
          end
          SER_STOP: if (rx_sub_r == TICK_BIT_END) begin
            // Only the first stop bit is checked; the line then idles
            rbr_r      <= rx_shift_r;
            dr_r       <= 1'b1;
            rx_state_r <= SER_IDLE;
            if (dr_r) oe_r <= 1'b1;
            if (rx_pe_r) pe_r <= 1'b1;
            if (!rx_lvl) fe_r <= 1'b1;
            if (!rx_lvl && rx_shift_r == 8'h00) bi_r <= 1'b1;
          end
          default: rx_state_r <= SER_IDLE;
        endcase
      end
    end
  end

  // Modem deltas: a pin edge in the read cycle survives the clear
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in || blk_clr) begin
      ms_prev_r <= 4'hF;
      delta_r   <= 4'h0;
    end else begin
      ms_prev_r <= ms_lvl;
      delta_r   <= ((rd && reg_req_in.addr == OFS_MSR) ? 4'h0 : delta_r) | (ms_lvl & ~ms_prev_r);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt priority and read-back
  // ----------------------------------------------------------------
  always_comb begin
    if (ier_r[IER_RLS] && (oe_r || pe_r || fe_r || bi_r)) iir_id = IID_RLS;
    else if (ier_r[IER_RDA] && dr_r) iir_id = IID_RDA;
    else if (ier_r[IER_THRE] && thre_int_r) iir_id = IID_THRE;
    else if (ier_r[IER_MS] && |delta_r) iir_id = IID_MS;
    else iir_id = IID_NONE;
  end
  assign int_pend = !iir_id[0];

  // Read data is frozen into the output flop, so a read sees one snapshot
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in || blk_clr) begin
      reg_rdata_out <= RST_BYTE;
    end else if (rd) begin
      case (reg_req_in.addr)
        OFS_DATA: reg_rdata_out <= access ? dll_r : rbr_r;
        OFS_IER:  reg_rdata_out <= access ? dhl_r : {4'h0, ier_r};
        OFS_IIR:  reg_rdata_out <= {fifo_en_r, fifo_en_r, 2'b00, iir_id};
        OFS_LCR:  reg_rdata_out <= lcr_r;
        OFS_MCR:  reg_rdata_out <= mcr_r;
        OFS_LSR:  reg_rdata_out <= {1'b0, !thr_full_r && tx_state_r == SER_IDLE, !thr_full_r,
                                    bi_r, fe_r, pe_r, oe_r, dr_r};
        OFS_MSR:  reg_rdata_out <= {~ms_lvl, delta_r};
        default:  reg_rdata_out <= scr_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in || blk_clr) begin
      txd_out           <= 1'b1;
      dtr_n_out         <= 1'b1;
      rts_n_out         <= 1'b1;
      irq_out           <= 1'b0;
      low_power_ack_out <= 1'b0;
    end else begin
      txd_out           <= tx_line & ~lcr_r[LCR_BREAK];
      dtr_n_out         <= ~mcr_r[MCR_DTR];
      rts_n_out         <= ~mcr_r[MCR_RTS];
      irq_out           <= int_pend & mcr_r[MCR_GATE];
      low_power_ack_out <= low_power_req_in && tx_state_r == SER_IDLE && rx_state_r == SER_IDLE;
    end
  end

  property p_irq_gate;
    !mcr_r[MCR_GATE] |=> !irq_out;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt not blocked by gate");

  property p_irq_pend;
    mcr_r[MCR_GATE] && int_pend |=> irq_out;
  endproperty
  a_irq_pend: assert property (p_irq_pend) else $error("pending interrupt not signalled");

  property p_dll_read;
    rd && access && reg_req_in.addr == OFS_DATA |=> reg_rdata_out == $past(dll_r);
  endproperty
  a_dll_read: assert property (p_dll_read) else $error("divisor low read mismatch");

  property p_iir_read;
    rd && reg_req_in.addr == OFS_IIR |=> reg_rdata_out[0] == $past(!int_pend);
  endproperty
  a_iir_read: assert property (p_iir_read) else $error("identification pending bit wrong");

endmodule

// ==== bench/serial_peer.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Far terminal, 8 data bits, no parity, one stop
// ----------------------------------------------------------------
module serial_peer #(
  parameter int BIT_NS = 640
) (
  input  wire logic line_in,
  output logic      line_out
);
  logic [7:0] got_q[$];
  logic [7:0] b;
  initial line_out = 1'b1;
  always @(negedge line_in) begin
    #(BIT_NS / 2);
    if (!line_in) begin
      for (int i = 0; i < 8; i++) begin
        #(BIT_NS);
        b[i] = line_in;
      end
      #(BIT_NS);
      got_q.push_back(b);
    end
  end
  task automatic send(input logic [7:0] d);
    line_out = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      line_out = d[i];
      #(BIT_NS);
    end
    line_out = 1'b1;
    #(BIT_NS);
  endtask
endmodule

// ==== bench/test_uart_baud_and_buffer_core.sv ====
`timescale 1ns/1ps
module test_uart_baud_and_buffer_core;
  import uart_core_pkg::*;
  logic       clock_in = 1'b0;
  logic       arst_n_in = 1'b0;
  logic       psel = 1'b0;
  logic       mrst_n = 1'b1;
  logic       lp_req = 1'b0;
  logic       ext_sel = 1'b0;
  logic       ext_clk = 1'b0;
  logic [3:0] modem_n = 4'hF;
  reg_req_t   req = '0;
  logic       rxd, txd, dtr_n, rts_n, irq, baud16, lp_ack, prev;
  logic [7:0] rdata, b;
  logic [31:0] seed = 32'h7472F40B;
  logic [7:0] sent_q[$];
  int         failures = 0;
  int         n_tests = 0;
  int         rises, lows, p;

  uart_baud_and_buffer_core dut (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .power_select_in(psel), .main_rail_reset_n_in(mrst_n), .low_power_req_in(lp_req),
    .external_clock_select_in(ext_sel), .ext_baud_clk_in(ext_clk), .reg_req_in(req),
    .rxd_in(rxd), .cts_n_in(modem_n[0]), .dsr_n_in(modem_n[1]), .ri_n_in(modem_n[2]),
    .dcd_n_in(modem_n[3]), .reg_rdata_out(rdata), .txd_out(txd), .dtr_n_out(dtr_n),
    .rts_n_out(rts_n), .irq_out(irq), .baud16_out(baud16), .low_power_ack_out(lp_ack));
  serial_peer peer (.line_in(txd), .line_out(rxd));

  initial forever #10 clock_in = ~clock_in;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic stop_test();
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(negedge clock_in);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clock_in);
    req = '0;
    @(negedge clock_in);
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check(rdata, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  initial begin
    idle(8);
    check({txd, dtr_n, rts_n, irq}, 8'h0E);
    idle(8);
    arst_n_in = 1'b1;
    rd_chk(OFS_IIR, 8'h01);
    rd_chk(OFS_LSR, 8'h60);
    bus(1'b1, OFS_LSR, 8'h1F);
    rd_chk(OFS_LSR, 8'h60);
    b = rnd();
    bus(1'b1, OFS_SCR, b);
    rd_chk(OFS_SCR, b);
    // ----------------------------------------------------------------
    // Divider waveform per divisor, fast source
    // ----------------------------------------------------------------
    bus(1'b1, OFS_LCR, 8'h83);
    bus(1'b1, OFS_IER, 8'h80);
    rd_chk(OFS_IER, 8'h80);
    for (int d = 4; d >= 0; d--) begin
      bus(1'b1, OFS_DATA, 8'(d));
      p = (d == 0) ? 3 : (d == 1) ? 2 : d;
      idle(6);
      rises = 0;
      lows = 0;
      prev = baud16;
      repeat (12 * p) begin
        @(negedge clock_in);
        rises += int'(baud16 && !prev);
        lows += int'(!baud16);
        prev = baud16;
      end
      check(8'(rises), 8'd12);
      if (d != 0) check(8'(lows), (d >= 3) ? 8'd24 : 8'd12);
    end
    bus(1'b1, OFS_DATA, 8'h02);
    rd_chk(OFS_DATA, 8'h02);
    bus(1'b1, OFS_LCR, 8'h03);
    // ----------------------------------------------------------------
    // Interrupt gate and identification
    // ----------------------------------------------------------------
    bus(1'b1, OFS_IER, 8'h02);
    rd_chk(OFS_IER, 8'h02);
    // First byte raises the empty interrupt once it moves to the shifter
    b = rnd();
    sent_q.push_back(b);
    bus(1'b1, OFS_DATA, b);
    idle(3);
    check(irq, 1'b0);
    bus(1'b1, OFS_MCR, 8'h0B);
    idle(3);
    check({irq, dtr_n, rts_n}, 8'h04);
    rd_chk(OFS_IIR, 8'h02);
    idle(3);
    check(irq, 1'b0);
    // ----------------------------------------------------------------
    // Back to back transmit, then receive
    // ----------------------------------------------------------------
    repeat (1) begin
      b = rnd();
      sent_q.push_back(b);
      bus(1'b1, OFS_DATA, b);
    end
    for (int n = 0; peer.got_q.size() < 2; n++) begin
      if (n > 2000) begin
        failures++;
        stop_test();
      end
      idle(1);
    end
    foreach (sent_q[i]) check(peer.got_q[i], sent_q[i]);
    repeat (2) begin
      b = rnd();
      peer.send(b);
      idle(8);
      rd_chk(OFS_LSR, 8'h61);
      rd_chk(OFS_DATA, b);
      rd_chk(OFS_LSR, 8'h60);
    end
    modem_n = 4'h0;
    idle(6);
    rd_chk(OFS_MSR, 8'hF0);
    // External source: one tick per pin rise, fast select ignored
    ext_sel = 1'b1;
    idle(6);
    rises = 0;
    prev = baud16;
    repeat (16) begin
      ext_clk = 1'b1;
      repeat (4) begin
        @(negedge clock_in);
        rises += int'(baud16 && !prev);
        prev = baud16;
      end
      ext_clk = 1'b0;
      repeat (4) begin
        @(negedge clock_in);
        rises += int'(baud16 && !prev);
        prev = baud16;
      end
    end
    check(8'(rises), 8'h08);
    ext_sel = 1'b0;
    lp_req = 1'b1;
    idle(20);
    check(lp_ack, 1'b1);
    lp_req = 1'b0;
    // ----------------------------------------------------------------
    // Main rail reset only counts with power select high
    // ----------------------------------------------------------------
    for (int s = 0; s < 2; s++) begin
      psel = s[0];
      bus(1'b1, OFS_SCR, 8'hA5);
      mrst_n = 1'b0;
      idle(8);
      mrst_n = 1'b1;
      idle(4);
      rd_chk(OFS_SCR, s[0] ? 8'h00 : 8'hA5);
    end
    stop_test();
  end
endmodule
